// ### afcr_config_regs.sv
// Our own choice: the plain strobed port.
`default_nettype none

module afcr_config_regs
  import afcr_pkg::*;
#(
  parameter int MV_W = MV_WIDTH
)
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       clockEn,
  input  wire logic [ADDR_WIDTH-1:0]      regAddr,
  input  wire logic [REG_WIDTH-1:0]       regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [REG_WIDTH-1:0]       regRdData,
  output logic      [CHANNELS-1:0]        bandwidthWide,
  output logic      [CHANNELS-1:0]        channelPowered,
  output logic                            deviceAsleep,
  output logic                            internalRefOn,
  output logic                            singleDataRate,
  output logic      [CHANNELS*SPAN_W-1:0] spanCodes,
  output logic      [CHANNELS*MV_W-1:0]   spanHalfMv,
  output logic      [CHANNELS*MV_W-1:0]   cmLimitMv,
  output logic      [CHANNELS-1:0]        codeInvalid
);

  // ==========================================================
  // Register storage
  logic [REG_WIDTH-1:0] bwPdReg;
  logic [REG_WIDTH-1:0] refRateReg;
  logic [REG_WIDTH-1:0] spanLoReg;
  logic [REG_WIDTH-1:0] spanHiReg;
  logic [REG_WIDTH-1:0] cmPdReg;
  logic [REG_WIDTH-1:0] cmGlobalReg;
  logic [REG_WIDTH-1:0] next_bwPdReg;
  logic [REG_WIDTH-1:0] next_refRateReg;
  logic [REG_WIDTH-1:0] next_spanLoReg;
  logic [REG_WIDTH-1:0] next_spanHiReg;
  logic [REG_WIDTH-1:0] next_cmPdReg;
  logic [REG_WIDTH-1:0] next_cmGlobalReg;
  logic [REG_WIDTH-1:0] next_regRdData;
  logic [5:0]           wrSel;
  logic [5:0]           rdSel;

  // ==========================================================
  // Decoded control
  logic [CHANNELS-1:0]        next_bandwidthWide;
  logic [CHANNELS-1:0]        next_channelPowered;
  logic                       next_deviceAsleep;
  logic                       next_internalRefOn;
  logic                       next_singleDataRate;
  logic [CHANNELS*SPAN_W-1:0] next_spanCodes;
  logic [CHANNELS*MV_W-1:0]   next_spanHalfMv;
  logic [CHANNELS*MV_W-1:0]   next_cmLimitMv;
  logic [CHANNELS-1:0]        next_codeInvalid;
  logic [CHANNELS-1:0]        spanValid;
  logic [CHANNELS-1:0]        cmValid;
  logic [1:0]                 sleepCode;
  logic                       lowGroupSleep;
  logic                       highGroupSleep;
  logic                       cmOverride;

  // ==========================================================
  // Address decode, one select bit per register
  function automatic logic [5:0] decodeAddr
  (
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [5:0] sel;
    sel = 6'h00;
    if (addr == ADDR_BW_PD)
    begin
      sel[0] = 1'b1;
    end
    else if (addr == ADDR_REF_RATE)
    begin
      sel[1] = 1'b1;
    end
    else if (addr == ADDR_SPAN_LO)
    begin
      sel[2] = 1'b1;
    end
    else if (addr == ADDR_SPAN_HI)
    begin
      sel[3] = 1'b1;
    end
    else if (addr == ADDR_CM_PD)
    begin
      sel[4] = 1'b1;
    end
    else if (addr == ADDR_CM_GLOBAL)
    begin
      sel[5] = 1'b1;
    end
    return sel;
  endfunction : decodeAddr

  // ==========================================================
  // Register write path
  always_comb
  begin
    wrSel            = decodeAddr(regAddr);
    next_bwPdReg     = bwPdReg;
    next_refRateReg  = refRateReg;
    next_spanLoReg   = spanLoReg;
    next_spanHiReg   = spanHiReg;
    next_cmPdReg     = cmPdReg;
    next_cmGlobalReg = cmGlobalReg;
    // All bits stored, reserved ones too
    if (regWrite)
    begin
      if (wrSel[0])
      begin
        next_bwPdReg = regWrData;
      end
      else if (wrSel[1])
      begin
        next_refRateReg = regWrData;
      end
      else if (wrSel[2])
      begin
        next_spanLoReg = regWrData;
      end
      else if (wrSel[3])
      begin
        next_spanHiReg = regWrData;
      end
      else if (wrSel[4])
      begin
        next_cmPdReg = regWrData;
      end
      else if (wrSel[5])
      begin
        next_cmGlobalReg = regWrData;
      end
    end
  end

  // ==========================================================
  // Register read path
  always_comb
  begin
    rdSel          = decodeAddr(regAddr);
    next_regRdData = REG_RESET;
    if (regRead)
    begin
      if (rdSel[0])
      begin
        next_regRdData = bwPdReg;
      end
      else if (rdSel[1])
      begin
        next_regRdData = refRateReg;
      end
      else if (rdSel[2])
      begin
        next_regRdData = spanLoReg;
      end
      else if (rdSel[3])
      begin
        next_regRdData = spanHiReg;
      end
      else if (rdSel[4])
      begin
        next_regRdData = cmPdReg;
      end
      else if (rdSel[5])
      begin
        next_regRdData = cmGlobalReg;
      end
      else
      begin
        next_regRdData = REG_RESET;
      end
    end
  end

  // ==========================================================
  // Register flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bwPdReg     <= REG_RESET;
      refRateReg  <= REG_RESET;
      spanLoReg   <= REG_RESET;
      spanHiReg   <= REG_RESET;
      cmPdReg     <= REG_RESET;
      cmGlobalReg <= REG_RESET;
      regRdData   <= REG_RESET;
    end
    else if (clockEn)
    begin
      bwPdReg     <= next_bwPdReg;
      refRateReg  <= next_refRateReg;
      spanLoReg   <= next_spanLoReg;
      spanHiReg   <= next_spanHiReg;
      cmPdReg     <= next_cmPdReg;
      cmGlobalReg <= next_cmGlobalReg;
      regRdData   <= next_regRdData;
    end
  end

  // ==========================================================
  // Power, reference and interface rate
  always_comb
  begin
    sleepCode           = next_bwPdReg[CH_SLEEP_LSB +: 2];
    lowGroupSleep       = (sleepCode == SLEEP_LOW) || (sleepCode == SLEEP_ALL);
    highGroupSleep      = (sleepCode == SLEEP_HIGH) || (sleepCode == SLEEP_ALL);
    next_deviceAsleep   = next_cmPdReg[DEV_SLEEP_BIT];
    next_internalRefOn  = !next_refRateReg[REF_OFF_BIT];
    next_singleDataRate = next_refRateReg[RATE_BIT];
    // Bit i of the field drives channel i+1
    next_bandwidthWide  = next_bwPdReg[BW_LSB +: CHANNELS];
    next_spanCodes      = {next_spanHiReg, next_spanLoReg};
    cmOverride          = next_cmGlobalReg[CM_OVERRIDE_BIT];
    next_channelPowered = '0;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (i < GROUP_SIZE)
      begin
        next_channelPowered[i] = !next_deviceAsleep && !lowGroupSleep;
      end
      else
      begin
        next_channelPowered[i] = !next_deviceAsleep && !highGroupSleep;
      end
    end
  end

  // ==========================================================
  // Per-channel span and common-mode decode
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
      localparam bit HIGH_GROUP = (ch >= GROUP_SIZE);
      logic       groupEnable;
      logic [1:0] rangeCode;

      assign groupEnable = HIGH_GROUP ? next_cmPdReg[CM_HI_EN_BIT]
                                      : next_cmPdReg[CM_LO_EN_BIT];
      assign rangeCode   = HIGH_GROUP ? next_cmPdReg[CM_HI_RNG_LSB +: 2]
                                      : next_cmPdReg[CM_LO_RNG_LSB +: 2];

      afcr_span_decode #(
        .MV_W (MV_W)
      ) u_span (
        .spanCode   (next_spanCodes[ch*SPAN_W +: SPAN_W]),
        .halfSpanMv (next_spanHalfMv[ch*MV_W +: MV_W]),
        .codeValid  (spanValid[ch])
      );

      afcr_cm_decode #(
        .MV_W (MV_W)
      ) u_cm (
        .globalOverride (cmOverride),
        .groupEnable    (groupEnable),
        .rangeCode      (rangeCode),
        .halfSpanMv     (next_spanHalfMv[ch*MV_W +: MV_W]),
        .cmLimitMv      (next_cmLimitMv[ch*MV_W +: MV_W]),
        .codeValid      (cmValid[ch])
      );
    end
  endgenerate

  assign next_codeInvalid = ~(spanValid & cmValid);

  // ==========================================================
  // Decoded output flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bandwidthWide  <= '0;
      channelPowered <= '1;
      deviceAsleep   <= 1'b0;
      internalRefOn  <= 1'b1;
      singleDataRate <= 1'b0;
      spanCodes      <= '0;
      spanHalfMv     <= {CHANNELS{MV_W'(MV_5V)}};
      cmLimitMv      <= {CHANNELS{MV_W'(MV_12V)}};
      codeInvalid    <= '0;
    end
    else if (clockEn)
    begin
      bandwidthWide  <= next_bandwidthWide;
      channelPowered <= next_channelPowered;
      deviceAsleep   <= next_deviceAsleep;
      internalRefOn  <= next_internalRefOn;
      singleDataRate <= next_singleDataRate;
      spanCodes      <= next_spanCodes;
      spanHalfMv     <= next_spanHalfMv;
      cmLimitMv      <= next_cmLimitMv;
      codeInvalid    <= next_codeInvalid;
    end
  end

endmodule : afcr_config_regs

`default_nettype wire

// ### afcr_pkg.sv
// Summary of operation
// - Bandwidth bits 9:2, bit 9 is channel 8
// - Bandwidth bit: 0 low-noise, 1 wide
// - Bits 1:0: none, 5-8, 1-4, all asleep
// - Second register bit 11 turns internal reference off
// - Second register bit 8: 0 DDR, 1 SDR
// - Four-bit span per channel, codes 0-5
// - Common-mode codes: half span, 6V, 12V
// - Bits 3 and 2 enable group common-mode control
// - Common-mode register bit 0 sleeps whole device
// - Sixteen-bit read/write registers, all reset zero
// - Global override clear forces 12V common mode
`default_nettype none

package afcr_pkg;

  // ==========================================================
  // Register map
  localparam int          REG_WIDTH       = 16;
  localparam int          ADDR_WIDTH      = 8;
  localparam logic [7:0]  ADDR_BW_PD      = 8'hC0;
  localparam logic [7:0]  ADDR_REF_RATE   = 8'hC1;
  localparam logic [7:0]  ADDR_SPAN_LO    = 8'hC2;
  localparam logic [7:0]  ADDR_SPAN_HI    = 8'hC3;
  localparam logic [7:0]  ADDR_CM_PD      = 8'hC4;
  localparam logic [7:0]  ADDR_CM_GLOBAL  = 8'hC5;
  localparam logic [15:0] REG_RESET       = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int          CHANNELS        = 8;
  localparam int          GROUP_SIZE      = 4;
  localparam int          BW_LSB          = 2;
  localparam int          CH_SLEEP_LSB    = 0;
  localparam int          REF_OFF_BIT     = 11;
  localparam int          RATE_BIT        = 8;
  localparam int          SPAN_W          = 4;
  localparam int          CM_HI_RNG_LSB   = 8;
  localparam int          CM_LO_RNG_LSB   = 6;
  localparam int          CM_HI_EN_BIT    = 3;
  localparam int          CM_LO_EN_BIT    = 2;
  localparam int          DEV_SLEEP_BIT   = 0;
  localparam int          CM_OVERRIDE_BIT = 4;

  // ==========================================================
  // Field encodings
  localparam logic [1:0]  SLEEP_NONE      = 2'h0;
  localparam logic [1:0]  SLEEP_HIGH      = 2'h1;
  localparam logic [1:0]  SLEEP_LOW       = 2'h2;
  localparam logic [1:0]  SLEEP_ALL       = 2'h3;
  localparam logic [1:0]  CM_HALF_SPAN    = 2'h0;
  localparam logic [1:0]  CM_6V           = 2'h1;
  localparam logic [1:0]  CM_12V          = 2'h2;

  // ==========================================================
  // Spans in millivolts (half of full swing)
  localparam int          MV_WIDTH        = 14;
  localparam logic [13:0] MV_5V           = 14'h1388;
  localparam logic [13:0] MV_3V5          = 14'h0DAC;
  localparam logic [13:0] MV_2V5          = 14'h09C4;
  localparam logic [13:0] MV_7V           = 14'h1B58;
  localparam logic [13:0] MV_10V          = 14'h2710;
  localparam logic [13:0] MV_12V          = 14'h2EE0;
  localparam logic [13:0] MV_6V           = 14'h1770;

  typedef enum logic [3:0] {
    AFCR_SPAN_5V  = 4'h0,
    AFCR_SPAN_3V5 = 4'h1,
    AFCR_SPAN_2V5 = 4'h2,
    AFCR_SPAN_7V  = 4'h3,
    AFCR_SPAN_10V = 4'h4,
    AFCR_SPAN_12V = 4'h5
  } afcr_span_t;

endpackage : afcr_pkg

`default_nettype wire

// ### afcr_span_decode.sv
`default_nettype none

module afcr_span_decode
  import afcr_pkg::*;
#(
  parameter int MV_W = MV_WIDTH
)
(
  input  wire logic [3:0]      spanCode,
  output logic      [MV_W-1:0] halfSpanMv,
  output logic                 codeValid
);

  // ==========================================================
  // Span code to half-swing millivolts
  always_comb
  begin
    codeValid  = 1'b1;
    halfSpanMv = MV_W'(MV_5V);
    case (spanCode)
      AFCR_SPAN_5V:  halfSpanMv = MV_W'(MV_5V);
      AFCR_SPAN_3V5: halfSpanMv = MV_W'(MV_3V5);
      AFCR_SPAN_2V5: halfSpanMv = MV_W'(MV_2V5);
      AFCR_SPAN_7V:  halfSpanMv = MV_W'(MV_7V);
      AFCR_SPAN_10V: halfSpanMv = MV_W'(MV_10V);
      AFCR_SPAN_12V: halfSpanMv = MV_W'(MV_12V);
      default:
      begin
        // Undefined code: flagged, falls back to 5V
        codeValid  = 1'b0;
        halfSpanMv = MV_W'(MV_5V);
      end
    endcase
  end

endmodule : afcr_span_decode

`default_nettype wire

// ### afcr_cm_decode.sv
`default_nettype none

module afcr_cm_decode
  import afcr_pkg::*;
#(
  parameter int MV_W = MV_WIDTH
)
(
  input  wire logic            globalOverride,
  input  wire logic            groupEnable,
  input  wire logic [1:0]      rangeCode,
  input  wire logic [MV_W-1:0] halfSpanMv,
  output logic      [MV_W-1:0] cmLimitMv,
  output logic                 codeValid
);

  // ==========================================================
  // Common-mode limit for one channel
  logic [MV_W-1:0] halfRangeMv;

  // Half of the selected span magnitude
  assign halfRangeMv = {1'b0, halfSpanMv[MV_W-1:1]};

  always_comb
  begin
    codeValid = 1'b1;
    cmLimitMv = MV_W'(MV_12V);
    if (!globalOverride)
    begin
      cmLimitMv = MV_W'(MV_12V);
    end
    else if (!groupEnable)
    begin
      // Wide control off: limit follows the span
      cmLimitMv = halfRangeMv;
    end
    else
    begin
      case (rangeCode)
        CM_HALF_SPAN: cmLimitMv = halfRangeMv;
        CM_6V:        cmLimitMv = MV_W'(MV_6V);
        CM_12V:       cmLimitMv = MV_W'(MV_12V);
        default:
        begin
          codeValid = 1'b0;
          cmLimitMv = MV_W'(MV_12V);
        end
      endcase
    end
  end

endmodule : afcr_cm_decode

`default_nettype wire

// ### afcr_config_regs_assertions.sv
`default_nettype none

module afcr_config_regs_assertions
  import afcr_pkg::*;
#(
  parameter int MV_W = MV_WIDTH
)
(
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        clockEn,
  input wire logic [ADDR_WIDTH-1:0]       regAddr,
  input wire logic [REG_WIDTH-1:0]        regWrData,
  input wire logic                        regWrite,
  input wire logic                        regRead,
  input wire logic [REG_WIDTH-1:0]        regRdData,
  input wire logic [CHANNELS-1:0]         bandwidthWide,
  input wire logic [CHANNELS-1:0]         channelPowered,
  input wire logic                        deviceAsleep,
  input wire logic                        internalRefOn,
  input wire logic                        singleDataRate,
  input wire logic [CHANNELS*SPAN_W-1:0]  spanCodes,
  input wire logic [CHANNELS*MV_W-1:0]    cmLimitMv
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ==========================================
  // Bus steps
  sequence s_wr(logic [7:0] a);
    clockEn && regWrite && regAddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    clockEn && regRead && regAddr == a;
  endsequence

  // ==========================================
  // Properties
  property p_bw;
    s_wr(ADDR_BW_PD) |=> bandwidthWide == $past(regWrData[9:2]);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth bits wrong");
  property p_sleep;
    s_wr(ADDR_BW_PD) |=> deviceAsleep
      || channelPowered == {{4{!$past(regWrData[0])}}, {4{!$past(regWrData[1])}}};
  endproperty
  a_sleep: assert property (p_sleep) else $error("group sleep wrong");
  property p_ref;
    s_wr(ADDR_REF_RATE) |=> internalRefOn == !$past(regWrData[11]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_rate;
    s_wr(ADDR_REF_RATE) |=> singleDataRate == $past(regWrData[8]);
  endproperty
  a_rate: assert property (p_rate) else $error("data rate wrong");
  property p_span;
    s_wr(ADDR_SPAN_HI) |=> spanCodes[31:16] == $past(regWrData);
  endproperty
  a_span: assert property (p_span) else $error("span codes wrong");
  property p_chip;
    s_wr(ADDR_CM_PD) |=> deviceAsleep == $past(regWrData[0])
      && (!deviceAsleep || channelPowered == 8'h00);
  endproperty
  a_chip: assert property (p_chip) else $error("chip sleep wrong");
  property p_rdback;
    s_wr(ADDR_BW_PD) ##1 s_rd(ADDR_BW_PD) |=> regRdData == $past(regWrData, 2);
  endproperty
  a_rdback: assert property (p_rdback) else $error("readback wrong");
  property p_rdidle;
    clockEn && !regRead |=> regRdData == 16'h0000;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data not idle");
  property p_cmglob;
    s_wr(ADDR_CM_GLOBAL) && !regWrData[4] |=> cmLimitMv == {CHANNELS{MV_12V}};
  endproperty
  a_cmglob: assert property (p_cmglob) else $error("global cm wrong");
endmodule : afcr_config_regs_assertions

bind afcr_config_regs afcr_config_regs_assertions #(.MV_W(MV_W)) u_chk (
  .clock, .rst, .clockEn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .bandwidthWide, .channelPowered, .deviceAsleep, .internalRefOn, .singleDataRate,
  .spanCodes, .cmLimitMv
);

`default_nettype wire

// ### tb_afcr_config_regs.sv
`default_nettype none

module tb_afcr_config_regs
  import afcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clock;
  logic         rst;
  logic         clockEn;
  logic [7:0]   regAddr;
  logic [15:0]  regWrData;
  logic         regWrite;
  logic         regRead;
  logic [15:0]  regRdData;
  logic [7:0]   bandwidthWide;
  logic [7:0]   channelPowered;
  logic         deviceAsleep;
  logic         internalRefOn;
  logic         singleDataRate;
  logic [31:0]  spanCodes;
  logic [111:0] spanHalfMv;
  logic [111:0] cmLimitMv;
  logic [7:0]   codeInvalid;
  int           miscompares;
  int           n_compared;
  logic [7:0]   slp [4] = '{8'hFF, 8'h0F, 8'hF0, 8'h00};
  logic [13:0]  mv  [6] = '{MV_5V, MV_3V5, MV_2V5, MV_7V, MV_10V, MV_12V};
  logic [13:0]  cm  [3] = '{MV_3V5, MV_6V, MV_12V};

  afcr_config_regs dut (
    .clock(clock), .rst(rst), .clockEn(clockEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .bandwidthWide(bandwidthWide),
    .channelPowered(channelPowered), .deviceAsleep(deviceAsleep),
    .internalRefOn(internalRefOn), .singleDataRate(singleDataRate),
    .spanCodes(spanCodes), .spanHalfMv(spanHalfMv), .cmLimitMv(cmLimitMv),
    .codeInvalid(codeInvalid)
  );

  // ==========================================
  // Tasks
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rd

  // Write then read in the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d);
    wr(a, d);
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdData, d);
  endtask : wrrd

  // ==========================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    repeat (3000) @(posedge clock);
    miscompares++;
    close_out();
  end

  // ==========================================
  // Tests
  initial
  begin
    rst = 1'b1;
    clockEn = 1'b1;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(ADDR_BW_PD + 8'(i), 16'h0000);
    chk({internalRefOn, singleDataRate, deviceAsleep, channelPowered, bandwidthWide},
        {3'b100, 8'hFF, 8'h00});
    chk(spanHalfMv, {8{MV_5V}});
    chk(cmLimitMv, {8{MV_12V}});
    wr(ADDR_BW_PD, 16'h0200);
    chk(bandwidthWide, 8'h80);
    wr(ADDR_BW_PD, 16'h0004);
    chk(bandwidthWide, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_BW_PD, 16'(c));
      chk(channelPowered, slp[c]);
    end
    wrrd(ADDR_BW_PD, 16'h03FF);
    wrrd(ADDR_CM_PD, 16'h03CD);
    wr(8'hC6, 16'hFFFF);
    rd(8'hC6, 16'h0000);
    rd(ADDR_BW_PD, 16'h03FF);
    wr(ADDR_REF_RATE, 16'h0800);
    chk({internalRefOn, singleDataRate}, 2'b00);
    wr(ADDR_REF_RATE, 16'h0100);
    chk({internalRefOn, singleDataRate}, 2'b11);
    for (int c = 0; c < 6; c++)
    begin
      wr(ADDR_SPAN_LO, {4{4'(c)}});
      wr(ADDR_SPAN_HI, {4{4'(5 - c)}});
      chk(spanCodes, {{4{4'(5 - c)}}, {4{4'(c)}}});
      chk(spanHalfMv, {{4{mv[5 - c]}}, {4{mv[c]}}});
    end
    wr(ADDR_SPAN_LO, 16'h0006);
    chk({codeInvalid, spanHalfMv[13:0]}, {8'h01, MV_5V});
    wr(ADDR_SPAN_LO, 16'h3333);
    wr(ADDR_CM_GLOBAL, 16'h0010);
    chk(codeInvalid, 8'hFF);
    for (int c = 0; c < 3; c++)
    begin
      wr(ADDR_CM_PD, 16'h0004 | 16'(c << 6));
      chk(cmLimitMv, {{4{MV_2V5}}, {4{cm[c]}}});
    end
    wr(ADDR_CM_PD, 16'h0108);
    chk(cmLimitMv, {{4{MV_6V}}, {4{MV_3V5}}});
    wr(ADDR_CM_GLOBAL, 16'h0000);
    chk(cmLimitMv, {8{MV_12V}});
    wr(ADDR_BW_PD, 16'h0000);
    wr(ADDR_CM_PD, 16'h0001);
    chk({deviceAsleep, channelPowered}, {1'b1, 8'h00});
    wr(ADDR_CM_PD, 16'h0000);
    chk({deviceAsleep, channelPowered}, {1'b0, 8'hFF});
    @(posedge clock);
    clockEn <= 1'b0;
    wr(ADDR_REF_RATE, 16'h0800);
    clockEn <= 1'b1;
    rd(ADDR_REF_RATE, 16'h0100);
    chk(internalRefOn, 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_REF_RATE, 16'h0000);
    chk({internalRefOn, singleDataRate}, 2'b10);
    close_out();
  end
endmodule : tb_afcr_config_regs

`default_nettype wire
